// file: eil_pin_src.sv
// Purpose: Behavioural source on the interrupt pin
// Assumes: Pin has a pull-up, idle high
// Notes: Edges land off the clock edge, as a real async pin would
`timescale 1ns/1ns
module eil_pin_src (
  input wire logic lvl, // Commanded pin level
  output logic irq_pin_n // Pin, active low
);
  initial irq_pin_n = 1'b1;
  always @(lvl) irq_pin_n <= #7 lvl;
endmodule

// file: eil_pkg.sv
// Purpose: Shared constants for the external interrupt pin latch
// Assumes: 8-bit status/control register at one offset
// Notes: Bit positions follow the usual status/control layout
package eil_pkg;
  localparam int unsigned EIL_AW = 4;
  localparam int unsigned EIL_DW = 8;
  localparam logic [3:0] EIL_OFF_SCR = 4'h0;
  localparam logic [3:0] EIL_OFF_BRK = 4'h1;
  localparam int unsigned EIL_BIT_MODE = 0;
  localparam int unsigned EIL_BIT_GATE = 1;
  localparam int unsigned EIL_BIT_ACK = 2;
  localparam int unsigned EIL_BIT_PEND = 3;
  localparam int unsigned EIL_BIT_BCP = 0;
  localparam logic [15:0] EIL_VECTOR_ADDR = 16'hFFFA;
  localparam logic [7:0] EIL_ZERO8 = 8'h00;
  localparam logic [1:0] EIL_ARM_DONE = 2'h3;
endpackage

// file: eil_sync.sv
// Purpose: Two-stage synchroniser for the interrupt pin
// Assumes: Pin idles high
// Notes: First stage feeds only the second
`timescale 1ns/1ns
module eil_sync (
  input wire logic mclk, // System clock
  input wire logic resetn, // Async reset, active low
  input wire logic din, // Asynchronous input
  output logic dout // Synchronised output
);
  typedef struct packed {
    logic s1;
    logic s2;
  } eil_sync_st_t;
  eil_sync_st_t st_q, st_d;
  always_comb begin
    st_d = st_q;
    st_d.s1 = din;
    st_d.s2 = st_q.s1;
  end
  // Reset to idle-high so no false edge at release
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st_q <= '{s1: 1'b1, s2: 1'b1};
    end else begin
      st_q <= st_d;
    end
  end
  assign dout = st_q.s2;
endmodule

// file: eil_top.sv
// Purpose: External interrupt pin latch with status/control register
// Assumes: Register port with one-cycle read latency; CPU supplies vector fetch pulse
// Notes: Break permit bit held in a second local register
`timescale 1ns/1ns
//
// Contract
// (R1) Low on the pin under active sensitivity latches a request.
// (R2) Vector fetch acknowledge clears the request latch.
// (R3) Writing one to the acknowledge bit clears the latch like vector fetch.
// (R4) Reset clears latch and sensitivity bit even with pin low.
// (R5) Edge mode: falling edges only; acknowledge clears at once.
// (R6) Level mode: clear needs acknowledge and pin high, either order.
// (R7) Level mode: request stays pending while pin stays low.
// (R8) Mask bit set withholds the request from the CPU.
// (R9) Pending flag shows latch state independent of mask.
// (R10) Falling edge after acknowledge write latches a new request.
// (R11) Serviced request supplies the vector from the fixed location pair.
// (R12) CPU global interrupt mask also blocks the request.
// (R13) Permit set: break-state acknowledge clears, stays cleared after break.
// (R14) Permit clear: break-state acknowledge write has no effect.
// (R15) Acknowledge bit is write-only, reads zero, reset clears it.
// (R16) Sensitivity bit read/write, reset clears; one adds low level.
// (R17) Mask bit read/write, reset clears; one disables requests.
// (R18) Software should mask level requests inside its service routine.
// (R19) Pin is synchronised before edge and level detection.
module eil_top
  import eil_pkg::*;
(
  input wire logic mclk, // System clock 50 MHz
  input wire logic resetn, // Async reset, active low
  input wire logic irq_pin_n, // External interrupt pin, active low
  input wire logic [eil_pkg::EIL_AW-1:0] addr, // Register address
  input wire logic [eil_pkg::EIL_DW-1:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  output logic [eil_pkg::EIL_DW-1:0] rdata, // Read data, cycle after rd
  input wire logic vec_fetch, // CPU vector fetch pulse for this source
  input wire logic cpu_local_request_gate, // CPU global interrupt mask
  input wire logic break_state, // Break state active
  output logic irq_req, // Request to CPU priority logic
  output logic [15:0] vec_addr // Vector location for the CPU
);
  import eil_pkg::*;

  typedef struct packed {
    logic latch;
    logic mode;
    logic gate;
    logic bcp;
    logic pin_prev;
    logic ack_seen;
    logic [1:0] arm;
    logic [EIL_DW-1:0] rdata;
  } eil_st_t;

  eil_st_t st_q, st_d;
  logic pin_s;
  logic fall;
  logic sw_ack;
  logic ack;
  logic clr;
  logic armed;
  logic lvl_set;
  logic lvl_clr;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchroniser
  eil_sync u_sync (
    .mclk(mclk),
    .resetn(resetn),
    .din(irq_pin_n),
    .dout(pin_s)
  ); // [R19]

  function automatic logic hit(input logic [EIL_AW-1:0] a, input logic [EIL_AW-1:0] off);
    hit = (a == off);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Latch control
  // Detection waits until the synchroniser refills after reset,
  // else a pin held low would look like a fresh falling edge
  assign armed = (st_q.arm == EIL_ARM_DONE); // [R4] [R19]
  assign fall = armed & st_q.pin_prev & ~pin_s; // [R1] [R5] [R19]
  // Break blocks the acknowledge write unless permit is set; vector fetch still clears
  assign sw_ack = wr & hit(addr, EIL_OFF_SCR) & wdata[EIL_BIT_ACK]
                  & (~break_state | st_q.bcp); // [R3] [R13] [R14]
  assign ack = sw_ack | vec_fetch; // [R2] [R3]
  // Level mode: a low pin keeps setting the latch
  assign lvl_set = armed & st_q.mode & ~pin_s; // [R1] [R7]
  assign clr = ack & (~st_q.mode | pin_s); // [R5] [R6]
  // Ack taken while the pin is low waits for the pin to return high
  assign lvl_clr = st_q.mode & st_q.ack_seen & pin_s; // [R6]

  always_comb begin
    st_d = st_q;
    st_d.pin_prev = pin_s;
    st_d.rdata = EIL_ZERO8;
    if (wr && hit(addr, EIL_OFF_SCR)) begin
      st_d.mode = wdata[EIL_BIT_MODE]; // [R16]
      st_d.gate = wdata[EIL_BIT_GATE]; // [R17]
    end
    if (wr && hit(addr, EIL_OFF_BRK)) begin
      st_d.bcp = wdata[EIL_BIT_BCP];
    end
    if (!armed) begin
      st_d.arm = st_q.arm + 2'h1;
    end
    // Set wins over clear so a coincident edge is not lost
    if (fall || lvl_set) begin
      st_d.latch = 1'b1; // [R1] [R5] [R7] [R10]
    end else if (clr || lvl_clr) begin
      st_d.latch = 1'b0; // [R2] [R3] [R6]
    end
    if (fall || !st_d.latch) begin
      st_d.ack_seen = 1'b0; // [R10]
    end else if (ack && st_q.mode) begin
      st_d.ack_seen = 1'b1; // [R6]
    end
    if (rd && hit(addr, EIL_OFF_SCR)) begin
      st_d.rdata[EIL_BIT_MODE] = st_q.mode;
      st_d.rdata[EIL_BIT_GATE] = st_q.gate;
      st_d.rdata[EIL_BIT_ACK] = 1'b0; // [R15]
      st_d.rdata[EIL_BIT_PEND] = st_q.latch; // [R9]
    end else if (rd && hit(addr, EIL_OFF_BRK)) begin
      st_d.rdata[EIL_BIT_BCP] = st_q.bcp;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st_q <= '{latch: 1'b0, mode: 1'b0, gate: 1'b0, bcp: 1'b0,
                pin_prev: 1'b1, ack_seen: 1'b0, arm: 2'h0,
                rdata: EIL_ZERO8}; // [R4] [R14] [R16] [R17]
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  assign rdata = st_q.rdata;
  assign irq_req = st_q.latch & ~st_q.gate & ~cpu_local_request_gate; // [R8] [R12]
  assign vec_addr = EIL_VECTOR_ADDR; // [R11]

  ////////////////////////////////////////////////////////////////////////
  // Checks
  property p_fall_sets;
    @(posedge mclk) disable iff (!resetn) fall |=> st_q.latch;
  endproperty
  a_fall_sets: assert property (p_fall_sets) else $error("edge lost"); // [R1]

  property p_edge_clear;
    @(posedge mclk) disable iff (!resetn)
      (vec_fetch && !st_q.mode && !fall) |=> !st_q.latch;
  endproperty
  a_edge_clear: assert property (p_edge_clear) else $error("fetch no clear"); // [R2]

  property p_sw_clear;
    @(posedge mclk) disable iff (!resetn)
      (sw_ack && !st_q.mode && !fall) |=> !st_q.latch;
  endproperty
  a_sw_clear: assert property (p_sw_clear) else $error("ack no clear"); // [R3]

  property p_level_hold;
    @(posedge mclk) disable iff (!resetn)
      (st_q.mode && st_q.latch && !pin_s) |=> st_q.latch;
  endproperty
  a_level_hold: assert property (p_level_hold) else $error("level dropped"); // [R7]

  property p_gate;
    @(posedge mclk) disable iff (!resetn) irq_req |-> (st_q.latch && !st_q.gate);
  endproperty
  a_gate: assert property (p_gate) else $error("masked request out"); // [R8]

  property p_pend_read;
    @(posedge mclk) disable iff (!resetn)
      (rd && hit(addr, EIL_OFF_SCR)) |=> (rdata[EIL_BIT_PEND] == $past(st_q.latch)
      && !rdata[EIL_BIT_ACK]);
  endproperty
  a_pend_read: assert property (p_pend_read) else $error("bad status read"); // [R9]

  property p_break_protect;
    @(posedge mclk) disable iff (!resetn)
      (break_state && !st_q.bcp && !vec_fetch && st_q.latch && !(st_q.ack_seen && pin_s))
      |=> st_q.latch;
  endproperty
  a_break_protect: assert property (p_break_protect) else $error("break clear"); // [R14]

  property p_cpu_mask;
    @(posedge mclk) disable iff (!resetn) cpu_local_request_gate |-> !irq_req;
  endproperty
  a_cpu_mask: assert property (p_cpu_mask) else $error("global mask ignored"); // [R12]

  ////////////////////////////////////////////////////////////////////////
  // Arming and level behaviour
  // Nothing may latch while the synchroniser refills after reset
  property p_arm_quiet;
    @(posedge mclk) disable iff (!resetn)
      (!armed && !st_q.latch) |=> !st_q.latch;
  endproperty
  a_arm_quiet: assert property (p_arm_quiet) else $error("latch during arming"); // [R4]

  property p_lvl_set;
    @(posedge mclk) disable iff (!resetn)
      (armed && st_q.mode && !pin_s) |=> st_q.latch;
  endproperty
  a_lvl_set: assert property (p_lvl_set) else $error("low level not latched"); // [R1]

  property p_lvl_ack_hold;
    @(posedge mclk) disable iff (!resetn)
      (armed && ack && st_q.mode && !pin_s) |=> st_q.latch;
  endproperty
  a_lvl_ack_hold: assert property (p_lvl_ack_hold) else $error("ack cleared low pin"); // [R7]

  // Ack before the pin returns high must not be forgotten
  property p_ack_remember;
    @(posedge mclk) disable iff (!resetn)
      (ack && st_q.mode && st_q.latch && !pin_s && !fall) |=> st_q.ack_seen;
  endproperty
  a_ack_remember: assert property (p_ack_remember) else $error("ack lost"); // [R6]

  property p_lvl_release;
    @(posedge mclk) disable iff (!resetn)
      (st_q.mode && st_q.ack_seen && pin_s && !fall) |=> !st_q.latch;
  endproperty
  a_lvl_release: assert property (p_lvl_release) else $error("pin high no clear"); // [R6]

  property p_lvl_ack_high;
    @(posedge mclk) disable iff (!resetn)
      (ack && st_q.mode && pin_s && !fall) |=> !st_q.latch;
  endproperty
  a_lvl_ack_high: assert property (p_lvl_ack_high) else $error("late ack no clear"); // [R6]

  ////////////////////////////////////////////////////////////////////////
  // Edge behaviour
  property p_only_set_paths;
    @(posedge mclk) disable iff (!resetn)
      (!fall && !(armed && st_q.mode && !pin_s) && !st_q.latch) |=> !st_q.latch;
  endproperty
  a_only_set_paths: assert property (p_only_set_paths) else $error("spurious set"); // [R5]

  // Edge mode keeps the request until some ack arrives
  property p_edge_keep;
    @(posedge mclk) disable iff (!resetn)
      (!st_q.mode && st_q.latch && !ack) |=> st_q.latch;
  endproperty
  a_edge_keep: assert property (p_edge_keep) else $error("edge request dropped"); // [R5]

  property p_new_edge;
    @(posedge mclk) disable iff (!resetn)
      fall |=> !st_q.ack_seen;
  endproperty
  a_new_edge: assert property (p_new_edge) else $error("stale ack kept"); // [R10]

  ////////////////////////////////////////////////////////////////////////
  // Register port
  property p_ack_zero;
    @(posedge mclk) disable iff (!resetn)
      rd |=> !rdata[EIL_BIT_ACK];
  endproperty
  a_ack_zero: assert property (p_ack_zero) else $error("ack bit read one"); // [R15]

  // Read data stands one cycle only, so idle cycles show zero
  property p_rd_idle;
    @(posedge mclk) disable iff (!resetn)
      !rd |=> (rdata == EIL_ZERO8);
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("stale read data"); // [R15]

  property p_mode_write;
    @(posedge mclk) disable iff (!resetn)
      (wr && hit(addr, EIL_OFF_SCR)) |=> (st_q.mode == $past(wdata[EIL_BIT_MODE]));
  endproperty
  a_mode_write: assert property (p_mode_write) else $error("mode write lost"); // [R16]

  property p_gate_write;
    @(posedge mclk) disable iff (!resetn)
      (wr && hit(addr, EIL_OFF_SCR)) |=> (st_q.gate == $past(wdata[EIL_BIT_GATE]));
  endproperty
  a_gate_write: assert property (p_gate_write) else $error("mask write lost"); // [R17]

  property p_mode_read;
    @(posedge mclk) disable iff (!resetn)
      (rd && hit(addr, EIL_OFF_SCR)) |=> (rdata[EIL_BIT_MODE] == $past(st_q.mode));
  endproperty
  a_mode_read: assert property (p_mode_read) else $error("mode read wrong"); // [R16]

  property p_gate_read;
    @(posedge mclk) disable iff (!resetn)
      (rd && hit(addr, EIL_OFF_SCR)) |=> (rdata[EIL_BIT_GATE] == $past(st_q.gate));
  endproperty
  a_gate_read: assert property (p_gate_read) else $error("mask read wrong"); // [R17]

  property p_mode_hold;
    @(posedge mclk) disable iff (!resetn)
      !(wr && hit(addr, EIL_OFF_SCR)) |=> $stable(st_q.mode);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode changed unasked"); // [R16]

  property p_gate_hold;
    @(posedge mclk) disable iff (!resetn)
      !(wr && hit(addr, EIL_OFF_SCR)) |=> $stable(st_q.gate);
  endproperty
  a_gate_hold: assert property (p_gate_hold) else $error("mask changed unasked"); // [R17]

  ////////////////////////////////////////////////////////////////////////
  // Break state
  property p_bcp_write;
    @(posedge mclk) disable iff (!resetn)
      (wr && hit(addr, EIL_OFF_BRK)) |=> (st_q.bcp == $past(wdata[EIL_BIT_BCP]));
  endproperty
  a_bcp_write: assert property (p_bcp_write) else $error("permit write lost"); // [R13]

  // With permit set a break-state ack must still clear an edge request
  property p_break_clear;
    @(posedge mclk) disable iff (!resetn)
      (wr && hit(addr, EIL_OFF_SCR) && wdata[EIL_BIT_ACK] && break_state && st_q.bcp
      && !st_q.mode && !fall) |=> !st_q.latch;
  endproperty
  a_break_clear: assert property (p_break_clear) else $error("permitted ack ignored"); // [R13]

  ////////////////////////////////////////////////////////////////////////
  // Request output
  property p_mask_blocks;
    @(posedge mclk) disable iff (!resetn)
      st_q.gate |-> !irq_req;
  endproperty
  a_mask_blocks: assert property (p_mask_blocks) else $error("mask leaks"); // [R8] [R17]

  property p_forward;
    @(posedge mclk) disable iff (!resetn)
      (st_q.latch && !st_q.gate && !cpu_local_request_gate) |-> irq_req;
  endproperty
  a_forward: assert property (p_forward) else $error("request withheld"); // [R8]

  property p_no_latch_quiet;
    @(posedge mclk) disable iff (!resetn)
      !st_q.latch |-> !irq_req;
  endproperty
  a_no_latch_quiet: assert property (p_no_latch_quiet) else $error("request w/o latch"); // [R8]

  property p_vector;
    @(posedge mclk) disable iff (!resetn)
      irq_req |-> (vec_addr == EIL_VECTOR_ADDR);
  endproperty
  a_vector: assert property (p_vector) else $error("wrong vector"); // [R11]

  // Synchronised pin lags the pin by exactly two edges once armed
  property p_pin_sync;
    @(posedge mclk) disable iff (!resetn)
      armed |-> (pin_s == $past(irq_pin_n, 2));
  endproperty
  a_pin_sync: assert property (p_pin_sync) else $error("sync delay wrong"); // [R19]
endmodule

// file: eil_top_bench.sv
// Purpose: Self-checking bench for the pin latch
// Assumes: Read data one cycle after rd
// Notes: Reads queue their expected value for the monitor
`timescale 1ns/1ns
module eil_top_bench;
  import eil_pkg::*;
  logic mclk = 1'b0, resetn = 1'b0, lvl = 1'b1, wr = 1'b0, rd = 1'b0, rd_d = 1'b0;
  logic vec_fetch = 1'b0, cpu_local_request_gate = 1'b0, break_state = 1'b0, irq_pin_n, irq_req;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, rdata, r;
  logic [15:0] vec_addr;
  logic [7:0] exp_q[$];
  int n_mismatch = 0, compares = 0, cyc = 0;
  always #10 mclk = ~mclk;
  eil_pin_src src (.lvl(lvl), .irq_pin_n(irq_pin_n));
  eil_top dut (.mclk(mclk), .resetn(resetn), .irq_pin_n(irq_pin_n), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .vec_fetch(vec_fetch),
    .cpu_local_request_gate(cpu_local_request_gate), .break_state(break_state), .irq_req(irq_req), .vec_addr(vec_addr));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk); addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge mclk); wr <= 1'b0;
  endtask
  task automatic rreg(input logic [3:0] a, input logic [7:0] e);
    @(posedge mclk); addr <= a; rd <= 1'b1; exp_q.push_back(e);
    @(posedge mclk); rd <= 1'b0;
  endtask
  // Six edges covers two sync stages plus the latch
  task automatic pin(input logic v);
    @(posedge mclk); lvl <= v;
    repeat (6) @(posedge mclk);
  endtask
  task automatic irq(input logic e);
    @(negedge mclk); check({15'h0, irq_req}, {15'h0, e});
  endtask
  ////////////////////////////////////////////////////////////////
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      end_sim();
    end
    if (rd_d) check({8'h00, rdata}, {8'h00, exp_q.pop_front()});
    rd_d <= rd;
  end
  initial begin
    void'($urandom(70503));
    repeat (5) @(posedge mclk);
    resetn <= 1'b1;
    rreg(EIL_OFF_SCR, 8'h00);
    rreg(EIL_OFF_BRK, 8'h00);
    rreg(4'h7, 8'h00);
    check(vec_addr, 16'hFFFA);
    $display("test 1 done");
    pin(0); rreg(EIL_OFF_SCR, 8'h08);
    irq(1);
    wreg(EIL_OFF_SCR, 8'h04); rreg(EIL_OFF_SCR, 8'h00);
    pin(1); pin(0); rreg(EIL_OFF_SCR, 8'h08);
    @(posedge mclk); vec_fetch <= 1'b1;
    @(posedge mclk); vec_fetch <= 1'b0;
    rreg(EIL_OFF_SCR, 8'h00);
    wreg(EIL_OFF_SCR, 8'h02); pin(1); pin(0);
    rreg(EIL_OFF_SCR, 8'h0A); irq(0);
    wreg(EIL_OFF_SCR, 8'h00); irq(1);
    @(posedge mclk); cpu_local_request_gate <= 1'b1;
    irq(0);
    @(posedge mclk); cpu_local_request_gate <= 1'b0;
    $display("test 2 done");
    // Level mode: an ack while low waits for the pin to rise
    wreg(EIL_OFF_SCR, 8'h05); rreg(EIL_OFF_SCR, 8'h09);
    pin(1); rreg(EIL_OFF_SCR, 8'h09);
    wreg(EIL_OFF_SCR, 8'h05); rreg(EIL_OFF_SCR, 8'h01);
    pin(0); wreg(EIL_OFF_SCR, 8'h07); rreg(EIL_OFF_SCR, 8'h0B); irq(0);
    pin(1); rreg(EIL_OFF_SCR, 8'h03);
    pin(0); pin(1);
    @(posedge mclk); break_state <= 1'b1;
    wreg(EIL_OFF_SCR, 8'h05); rreg(EIL_OFF_SCR, 8'h09);
    wreg(EIL_OFF_BRK, 8'h01); rreg(EIL_OFF_BRK, 8'h01);
    wreg(EIL_OFF_SCR, 8'h05);
    @(posedge mclk); break_state <= 1'b0;
    rreg(EIL_OFF_SCR, 8'h01);
    $display("test 3 done");
    repeat (4) begin
      r = 8'($urandom_range(3));
      wreg(EIL_OFF_SCR, r); rreg(EIL_OFF_SCR, r);
    end
    wreg(EIL_OFF_SCR, 8'h01); pin(0);
    @(posedge mclk); resetn <= 1'b0;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    rreg(EIL_OFF_SCR, 8'h00); rreg(EIL_OFF_BRK, 8'h00);
    pin(1);
    $display("test 4 done");
    repeat (3) @(posedge mclk);
    end_sim();
  end
endmodule
